// >>> hdl/fds_pkg.sv
// Shared constants for the floppy data separator and write precompensation block.
package fds_pkg;
  // Input pin bundle positions after synchronisation.
  localparam int unsigned PIN_OSC = 0;
  localparam int unsigned PIN_RAW_N = 1;
  localparam int unsigned PIN_DOUBLE_DENSITY_SELECT_N_N = 2;
  localparam int unsigned PIN_FAULT_N = 3;
  localparam int unsigned PIN_WGATE = 4;
  localparam int unsigned PIN_WIN = 5;
  localparam int unsigned PIN_AHEAD = 6;
  localparam int unsigned PIN_BEHIND = 7;
  localparam int unsigned PIN_INNER = 8;
  localparam int unsigned PIN_PH1_N = 9;
  localparam int unsigned PIN_PH2_N = 10;
  localparam int unsigned PIN_PH3_N = 11;
  localparam int unsigned PIN_PH4_N = 12;
  localparam int unsigned PIN_W = 13;
  // Reset image of the synchroniser: pulled-up and idle-high pins start at one.
  localparam logic [12:0] PIN_RST = 13'h1F0E;
  // Last phase of the read clock period, counted in oscillator edges, in each density.
  localparam logic [3:0] DIV_SD_LAST = 4'hF;
  localparam logic [3:0] DIV_DD_LAST = 4'h7;
  // Window thirds: phase below EARLY_END is early, at or above LATE_BEGIN is late.
  localparam logic [3:0] SD_EARLY_END = 4'h5;
  localparam logic [3:0] SD_LATE_BEGIN = 4'hB;
  localparam logic [3:0] DD_EARLY_END = 4'h3;
  localparam logic [3:0] DD_LATE_BEGIN = 4'h6;
  // Phase tap choices for the precompensated write pulse.
  localparam logic [1:0] TAP_NOMINAL = 2'h1;
  localparam logic [1:0] TAP_EARLY = 2'h1;
  localparam logic [1:0] TAP_LATE = 2'h2;
endpackage : fds_pkg

// >>> hdl/fds_pin_if.sv
// Carrier for raw pins and their synchronised copies.
`timescale 1ns/1ps
`default_nettype none
interface fds_pin_if #(
  parameter int unsigned W = 13
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface : fds_pin_if
`default_nettype wire

// >>> hdl/fds_sync.sv
// Two-stage synchroniser bank for asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module fds_sync #(
  parameter int unsigned W = 13,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Pins
  fds_pin_if.sync pins
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } fds_sync_t;

  fds_sync_t st;
  fds_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.meta = pins.raw;
    next_st.stable = st.meta;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '{meta: RST, stable: RST};
    end else begin
      st <= next_st;
    end
  end

  assign pins.synced = st.stable;
endmodule : fds_sync
`default_nettype wire

// >>> hdl/fds_top.sv
// Floppy data separator with read clock, pump outputs and write precompensation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Read clock is oscillator divided by 16 in single, by 8 in double density.
// - Write gate high disables recovery; both pumps float.
// - Recovery needs write gate and fault line low; pumps act only on read pulse.
// - Read edge early in window drives pump up high.
// - Read edge late in window drives pump down low, pump up floats.
// - Read edge in window centre leaves both pumps floating.
// - Pump time follows read pulse width; wide pulses fire both pumps.
// - Double density: write pulse leading edge picks a phase tap from shift hints.
// - Nominal and early use tap 2, late uses tap 3.
// - Strobe set on precompensated write edge, cleared by tap 4 leading edge.
// - Inner track flag low or single density passes write data straight through.
// - Density, inner track and read data pins read one when open.
module fds_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Read side pins
  input wire logic oscillator_clock_in_i,
  input wire logic raw_read_pulse_n_i,
  input wire logic double_density_select_n_i,
  input wire logic recovery_enable_fault_n_i,
  // Write side pins
  input wire logic write_gate_i,
  input wire logic write_pulse_in_i,
  input wire logic shift_ahead_i,
  input wire logic shift_behind_i,
  input wire logic inner_track_flag_i,
  input wire logic [3:0] phase_tap_n_i,
  // Read side outputs
  output logic read_clock_o,
  output logic pump_up_o,
  output logic pump_up_oe_n_o,
  output logic pump_down_n_o,
  output logic pump_down_oe_n_o,
  // Write side outputs
  output logic write_pulse_out_o,
  output logic phase_strobe_o
);
  fds_pin_if #(.W(fds_pkg::PIN_W)) pins ();

  assign pins.raw = {phase_tap_n_i, inner_track_flag_i, shift_behind_i, shift_ahead_i,
                     write_pulse_in_i, write_gate_i, recovery_enable_fault_n_i,
                     double_density_select_n_i, raw_read_pulse_n_i, oscillator_clock_in_i};

  // Open pins are pulled up at the pad; the synchroniser resets them to one.
  fds_sync #(.W(fds_pkg::PIN_W), .RST(fds_pkg::PIN_RST)) u_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .pins(pins)
  );

  // Position of the window phase, split into early, centre and late thirds.
  typedef enum logic [1:0] {
    THIRD_EARLY,
    THIRD_CENTRE,
    THIRD_LATE
  } fds_third_t;

  typedef struct packed {
    logic osc_d;
    logic raw_n_d;
    logic win_d;
    logic ph4_n_d;
    logic [3:0] phase;
    logic [1:0] tap;
    logic armed;
    logic rclk;
    logic pu;
    logic pu_oe_n;
    logic pd_n;
    logic pd_oe_n;
    logic wout;
    logic stb;
  } fds_state_t;

  fds_state_t st;
  fds_state_t next_st;

  logic osc;
  logic raw_n;
  logic double_density_select_n_n;
  logic win;
  logic ph4_n;
  logic osc_rise;
  logic raw_fall;
  logic win_rise;
  logic ph4_fall;
  logic rec_on;
  logic precomp_on;
  logic [3:0] last;
  logic [3:0] early_end;
  logic [3:0] late_begin;
  logic tap_active;
  fds_third_t third;

  always_comb begin
    osc = pins.synced[fds_pkg::PIN_OSC];
    raw_n = pins.synced[fds_pkg::PIN_RAW_N];
    double_density_select_n_n = pins.synced[fds_pkg::PIN_DOUBLE_DENSITY_SELECT_N_N];
    win = pins.synced[fds_pkg::PIN_WIN];
    ph4_n = pins.synced[fds_pkg::PIN_PH4_N];
    osc_rise = osc & ~st.osc_d;
    raw_fall = ~raw_n & st.raw_n_d;
    win_rise = win & ~st.win_d;
    ph4_fall = ~ph4_n & st.ph4_n_d;
    rec_on = ~pins.synced[fds_pkg::PIN_WGATE] & ~pins.synced[fds_pkg::PIN_FAULT_N];
    precomp_on = ~double_density_select_n_n & pins.synced[fds_pkg::PIN_INNER];
    last = double_density_select_n_n ? fds_pkg::DIV_SD_LAST : fds_pkg::DIV_DD_LAST;
    early_end = double_density_select_n_n ? fds_pkg::SD_EARLY_END : fds_pkg::DD_EARLY_END;
    late_begin = double_density_select_n_n ? fds_pkg::SD_LATE_BEGIN : fds_pkg::DD_LATE_BEGIN;
    // Classify the phase once, so both pumps judge an edge against the same third.
    if (st.phase < early_end) begin
      third = THIRD_EARLY;
    end else if (st.phase >= late_begin) begin
      third = THIRD_LATE;
    end else begin
      third = THIRD_CENTRE;
    end
    // The chosen tap is read from the synchronised bank, so it lags its pin like the rest.
    unique case (st.tap)
      2'h0: tap_active = ~pins.synced[fds_pkg::PIN_PH1_N];
      2'h1: tap_active = ~pins.synced[fds_pkg::PIN_PH2_N];
      2'h2: tap_active = ~pins.synced[fds_pkg::PIN_PH3_N];
      2'h3: tap_active = ~pins.synced[fds_pkg::PIN_PH4_N];
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.osc_d = osc;
    next_st.raw_n_d = raw_n;
    next_st.win_d = win;
    next_st.ph4_n_d = ph4_n;

    // The read clock is high for the second half of each window.
    if (osc_rise) begin
      next_st.phase = (st.phase >= last) ? 4'h0 : st.phase + 4'h1;
    end
    next_st.rclk = double_density_select_n_n ? st.phase[3] : st.phase[2];

    // A falling read pulse arms the pumps; while the pulse stays low they follow the
    // current third, so a wide pulse that runs from early into late fires both.
    next_st.armed = rec_on & ~raw_n & (raw_fall | st.armed);
    next_st.pu = 1'b0;
    next_st.pu_oe_n = 1'b1;
    next_st.pd_n = 1'b1;
    next_st.pd_oe_n = 1'b1;
    if (next_st.armed) begin
      unique case (third)
        THIRD_EARLY: begin
          next_st.pu = 1'b1;
          next_st.pu_oe_n = 1'b0;
        end
        THIRD_LATE: begin
          next_st.pd_n = 1'b0;
          next_st.pd_oe_n = 1'b0;
        end
        THIRD_CENTRE: begin
          // A centre edge needs no correction, so both stay floating.
        end
      endcase
    end

    // Write path: straight through unless double density on inner tracks.
    if (!precomp_on) begin
      next_st.wout = win;
      next_st.stb = 1'b0;
    end else begin
      if (win_rise) begin
        // The early case uses tap 2 as well; it only differs if the shift sense is kept.
        unique case ({pins.synced[fds_pkg::PIN_AHEAD], pins.synced[fds_pkg::PIN_BEHIND]})
          2'b10: next_st.tap = fds_pkg::TAP_EARLY;
          2'b01: next_st.tap = fds_pkg::TAP_LATE;
          2'b00, 2'b11: next_st.tap = fds_pkg::TAP_NOMINAL;
        endcase
        next_st.stb = 1'b1;
      end else if (ph4_fall) begin
        next_st.stb = 1'b0;
      end
      // Only the chosen tap, and only while the strobe stands, reaches the drive.
      next_st.wout = st.stb & tap_active;
    end
  end

  // Reset floats both pumps, parks the write output low and restarts the window.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '{
        osc_d: 1'b0,
        raw_n_d: 1'b1,
        win_d: 1'b0,
        ph4_n_d: 1'b1,
        phase: 4'h0,
        tap: fds_pkg::TAP_NOMINAL,
        armed: 1'b0,
        rclk: 1'b0,
        pu: 1'b0,
        pu_oe_n: 1'b1,
        pd_n: 1'b1,
        pd_oe_n: 1'b1,
        wout: 1'b0,
        stb: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  assign read_clock_o = st.rclk;
  assign pump_up_o = st.pu;
  assign pump_up_oe_n_o = st.pu_oe_n;
  assign pump_down_n_o = st.pd_n;
  assign pump_down_oe_n_o = st.pd_oe_n;
  assign write_pulse_out_o = st.wout;
  assign phase_strobe_o = st.stb;
endmodule : fds_top
`default_nettype wire

// >>> sim/fds_checker.sv
// Pin level checks for the floppy data separator block.
`timescale 1ns/1ps
`default_nettype none
module fds_checker (
  // Clock, reset and inputs
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic oscillator_clock_in_i,
  input wire logic raw_read_pulse_n_i,
  input wire logic double_density_select_n_i,
  input wire logic recovery_enable_fault_n_i,
  input wire logic write_gate_i,
  input wire logic write_pulse_in_i,
  input wire logic shift_ahead_i,
  input wire logic shift_behind_i,
  input wire logic inner_track_flag_i,
  input wire logic [3:0] phase_tap_n_i,
  // Outputs of the block
  input wire logic read_clock_o,
  input wire logic pump_up_o,
  input wire logic pump_up_oe_n_o,
  input wire logic pump_down_n_o,
  input wire logic pump_down_oe_n_o,
  input wire logic write_pulse_out_o,
  input wire logic phase_strobe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Five cycles of a level cover the two synchroniser stages and the output register.
  wire logic fl = pump_up_oe_n_o && pump_down_oe_n_o;
  wire logic pre = inner_track_flag_i && !double_density_select_n_i;
  a_gate_float: assert property (write_gate_i [*5] |-> fl)
    else $error("pump driven while writing");
  a_fault_float: assert property (recovery_enable_fault_n_i [*5] |-> fl)
    else $error("pump driven while recovery is off");
  a_idle_float: assert property (raw_read_pulse_n_i [*5] |-> fl)
    else $error("pump driven without a read pulse");
  a_pump_cause: assert property (!fl |-> !$past(raw_read_pulse_n_i, 3)
    && !$past(write_gate_i, 3)) else $error("pump without its cause");
  a_up_level: assert property (!pump_up_oe_n_o |-> pump_up_o)
    else $error("pump up driven low");
  a_down_level: assert property (!pump_down_oe_n_o |-> !pump_down_n_o)
    else $error("pump down driven high");
  a_pass_thru: assert property ((!pre) [*5] |->
    write_pulse_out_o == $past(write_pulse_in_i, 3))
    else $error("write data not passed through");
  a_pass_nostrobe: assert property ((!pre) [*5] |-> !phase_strobe_o)
    else $error("strobe raised without precompensation");
  a_strobe_rise: assert property ($rose(phase_strobe_o) |-> $past(write_pulse_in_i, 3)
    && !$past(write_pulse_in_i, 4)) else $error("strobe rose without a write edge");
  a_strobe_clear: assert property ($fell(phase_strobe_o) |-> !$past(phase_tap_n_i[3], 3))
    else $error("strobe cleared without tap four");
  a_tap_only: assert property (pre [*5] ##0 write_pulse_out_o |-> phase_strobe_o &&
    !($past(phase_tap_n_i[1], 3) && $past(phase_tap_n_i[2], 3))) else $error("wrong tap");
  c_up: cover property (!pump_up_oe_n_o);
  c_down: cover property (!pump_down_oe_n_o);
  c_strobe: cover property ($rose(phase_strobe_o));
endmodule // fds_checker
bind fds_top fds_checker chk (.*);
`default_nettype wire

// >>> sim/fds_far_model.sv
// Far side model: free running oscillator and four phase tap generator.
`timescale 1ns/1ps
`default_nettype none
module fds_far_model (
  // Strobe from the block
  input wire logic phase_strobe_i,
  // Oscillator and active low phase taps
  output logic osc_o,
  output logic [3:0] tap_n_o
);
  initial begin
    osc_o = 1'b0;
    #7;
    forever #125 osc_o = ~osc_o;
  end
  initial tap_n_o = 4'hF;
  // The 3 ns lag keeps tap edges away from the sampling edge of the block.
  always @(posedge phase_strobe_i) begin
    #3;
    for (int i = 0; i < 4; i++) begin
      tap_n_o[i] = 1'b0;
      #100 tap_n_o[i] = 1'b1;
    end
  end
endmodule // fds_far_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the floppy data separator block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("Error at %0t: got %h, expected %h", $time, (a), (e)); \
  end \
end
module testbench;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, raw_read_pulse_n_i = 1'b1;
  logic double_density_select_n_i = 1'b1, recovery_enable_fault_n_i = 1'b0;
  logic write_gate_i = 1'b0, write_pulse_in_i = 1'b0, inner_track_flag_i = 1'b1;
  logic shift_ahead_i = 1'b0, shift_behind_i = 1'b0;
  wire logic oscillator_clock_in_i;
  wire logic [3:0] phase_tap_n_i;
  logic read_clock_o, pump_up_o, pump_up_oe_n_o, pump_down_n_o, pump_down_oe_n_o;
  logic write_pulse_out_o, phase_strobe_o;
  logic up_s = 1'b0, dn_s = 1'b0, st_s = 1'b0, wo_s = 1'b0;
  logic [3:0] tp_s = 4'h0, t1, t2, t3;
  int failures = 0, checked = 0, oscs = 0, n;
  fds_top uut (.*);
  fds_far_model far (.phase_strobe_i(phase_strobe_o), .osc_o(oscillator_clock_in_i),
    .tap_n_o(phase_tap_n_i));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  // The tap history lines up with the three cycle lag of the write output.
  always @(posedge ref_clk_i) begin
    {t3, t2, t1} <= {t2, t1, phase_tap_n_i};
    if (!pump_up_oe_n_o && pump_up_o) up_s <= 1'b1;
    if (!pump_down_oe_n_o && !pump_down_n_o) dn_s <= 1'b1;
    if (phase_strobe_o) st_s <= 1'b1;
    if (write_pulse_out_o) wo_s <= 1'b1;
    if (write_pulse_out_o) tp_s <= tp_s | ~t3;
  end
  always @(posedge oscillator_clock_in_i) oscs++;
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  task automatic close_out;
    $display("Counts: %0d checked, %0d failures", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic div_chk(input logic sel, input int e);
    cyc(1);
    double_density_select_n_i = sel;
    cyc(40);
    repeat (2) @(posedge read_clock_o);
    n = oscs;
    @(posedge read_clock_o);
    `CHK(oscs - n, e)
  endtask
  task automatic read_at(input logic hi, input int o, input int lag, input int w,
    input logic up_e, input logic dn_e);
    if (hi) @(posedge read_clock_o);
    else @(negedge read_clock_o);
    repeat (o) @(posedge oscillator_clock_in_i);
    cyc(lag);
    {up_s, dn_s} = 2'h0;
    raw_read_pulse_n_i = 1'b0;
    cyc(w);
    raw_read_pulse_n_i = 1'b1;
    cyc(6);
    `CHK(up_s, up_e)
    `CHK(dn_s, dn_e)
  endtask
  task automatic wr_bit(input logic [1:0] h, input logic [3:0] tp, input logic st);
    {shift_ahead_i, shift_behind_i} = h;
    cyc(5);
    {st_s, wo_s, tp_s} = 6'h0;
    write_pulse_in_i = 1'b1;
    cyc(4);
    write_pulse_in_i = 1'b0;
    cyc(30);
    `CHK(tp_s, tp)
    `CHK(st_s, st)
    `CHK(wo_s, 1'b1)
    `CHK(phase_strobe_o, 1'b0)
  endtask
  initial begin
    cyc(5);
    sys_rst_i = 1'b0;
    cyc(10);
    div_chk(1'b1, 16);
    div_chk(1'b0, 8);
    $display("Test divide done");
    read_at(1'b0, 0, 2, 4, 1'b1, 1'b0);
    read_at(1'b1, 0, 2, 4, 1'b0, 1'b0);
    read_at(1'b1, 2, 5, 4, 1'b0, 1'b1);
    read_at(1'b0, 0, 2, 70, 1'b1, 1'b1);
    write_gate_i = 1'b1;
    read_at(1'b0, 0, 2, 70, 1'b0, 1'b0);
    {write_gate_i, recovery_enable_fault_n_i} = 2'h1;
    read_at(1'b0, 0, 2, 70, 1'b0, 1'b0);
    recovery_enable_fault_n_i = 1'b0;
    $display("Test pumps done");
    wr_bit(2'h0, 4'h2, 1'b1);
    wr_bit(2'h2, 4'h2, 1'b1);
    wr_bit(2'h1, 4'h4, 1'b1);
    inner_track_flag_i = 1'b0;
    wr_bit(2'h1, 4'h0, 1'b0);
    {inner_track_flag_i, double_density_select_n_i} = 2'h3;
    wr_bit(2'h1, 4'h0, 1'b0);
    $display("Test write done");
    close_out();
  end
  // The sequence needs about 31 us, so 500 us only trips on a real hang.
  initial begin
    #500000;
    failures++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
